// ==== design/dpx_arbiter.sv ====
// Exclusive-control command arbiter of a dual-interface tag.
// Assumes frame decoders on the same clock deliver command events, and
// that the tunnel write buffer reads combinationally at tun_rd_addr_o.
`timescale 1ns/10ps
module dpx_arbiter #(
  parameter int unsigned ANSWER_WAIT_CYC = dpx_pkg::ANSWER_WAIT_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        rf_cmd_start_i,
  input  wire logic        rf_cmd_tunnel_i,
  input  wire logic        rf_cmd_end_i,
  input  wire logic        rf_op_done_i,
  input  wire logic        rf_type_b_i,
  input  wire logic [63:0] card_id_i,
  input  wire logic [7:0]  stat1_i,
  input  wire logic [7:0]  stat2_i,
  input  wire logic [7:0]  sw1_i,
  input  wire logic [7:0]  sw2_i,
  input  wire logic [15:0] tun_addr_i,
  input  wire logic [7:0]  tun_len_i,
  input  wire logic [7:0]  tun_rd_data_i,
  input  wire logic        host_cmd_valid_i,
  input  wire logic        host_addr_match_i,
  input  wire logic        host_cmd_impl_i,
  input  wire logic [7:0]  host_cmd_code_i,
  input  wire logic        host_op_done_i,
  input  wire logic        host_rsp_ready_i,
  input  wire logic        rf_rsp_ready_i,
  output logic             host_op_start_o,
  output logic             host_rsp_valid_o,
  output logic [7:0]       host_rsp_data_o,
  output logic             host_rsp_last_o,
  output logic             rf_rsp_valid_o,
  output logic [7:0]       rf_rsp_data_o,
  output logic             rf_rsp_last_o,
  output logic [7:0]       tun_rd_addr_o,
  output logic             irq_o,
  output logic             exclusive_o,
  output logic             tun_err_o
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_RF_OP, ST_SER_OP, ST_TUN_RX,
    ST_AWAIT_HOST_ANSWER, ST_TUN_RSP
  } dpx_state_t;
  dpx_state_t         st_q, st_d;
  logic               rxdone_q, rxdone_d, irq_q, irq_d, err_q, err_d;
  logic               excl_q, excl_d, opst_q, opst_d, rfgo_q, rfgo_d;
  dpx_pkg::dpx_hkind_t hk_q, hk_d;
  logic [8:0]         hi_q, hi_d;
  logic               hv_q, hv_d, hl_q, hl_d;
  logic [7:0]         hd_q, hd_d, ra_q, ra_d;
  logic [3:0]         ri_q, ri_d;
  logic               rv_q, rv_d, rl_q, rl_d;
  logic [7:0]         rd_q, rd_d;
  logic               host_cmd, h_start, busy_rst, tmr_exp;
  dpx_pkg::dpx_hkind_t h_kind;
  logic [8:0]         h_nidx;
  logic [3:0]         r_nidx;
  logic [7:0]         h_byte, r_byte;
  logic               h_last, r_last;

  // ---------------------------------------------------------------------------
  // Answer-wait timer
  // ---------------------------------------------------------------------------
  dpx_wait_timer #(.LOAD(ANSWER_WAIT_CYC)) u_timer (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .run_i     (st_q == ST_AWAIT_HOST_ANSWER),
    .restart_i (busy_rst),
    .expired_o (tmr_exp)
  );

  // ---------------------------------------------------------------------------
  // Command arbitration
  // ---------------------------------------------------------------------------
  // Host commands arriving while a host reply streams are dropped; a reader start wins over a host command in idle
  assign host_cmd = host_cmd_valid_i && host_addr_match_i && !hv_q;
  always_comb begin
    st_d     = st_q;
    rxdone_d = rxdone_q;
    irq_d    = irq_q;
    err_d    = err_q;
    opst_d   = 1'b0;
    rfgo_d   = 1'b0;
    h_start  = 1'b0;
    h_kind   = dpx_pkg::DPX_HR_BUSY;
    busy_rst = 1'b0;
    case (st_q)
      ST_IDLE: begin
        irq_d    = 1'b0;
        rxdone_d = 1'b0;
        if (rf_cmd_start_i) begin
          st_d = rf_cmd_tunnel_i ? ST_TUN_RX : ST_RF_OP;
          if (host_cmd) begin
            h_start = 1'b1;
          end
        end else if (host_cmd) begin
          h_start = !host_cmd_impl_i;
          if (host_cmd_impl_i) begin
            st_d   = ST_SER_OP;
            opst_d = 1'b1;
          end
        end
      end
      ST_RF_OP: begin
        h_start = host_cmd;
        if (rf_op_done_i) begin
          st_d = ST_IDLE;
        end
      end
      ST_SER_OP: begin
        h_start = host_cmd;
        if (host_op_done_i) begin
          st_d = ST_IDLE;
        end
      end
      ST_TUN_RX: begin
        h_start = host_cmd;
        if (rf_cmd_end_i) begin
          rxdone_d = 1'b1;
        end
        // The interrupt waits until any busy reply has fully left
        if ((rxdone_q || rf_cmd_end_i) && !hv_q && !host_cmd) begin
          irq_d = 1'b1;
          st_d  = ST_AWAIT_HOST_ANSWER;
        end
      end
      ST_AWAIT_HOST_ANSWER: begin
        if (host_cmd) begin
          h_start = 1'b1;
          if (host_cmd_code_i == dpx_pkg::FETCH_REQUEST_CMD) begin
            h_kind = dpx_pkg::DPX_HR_FETCH;
          end else if (host_cmd_code_i == dpx_pkg::ANS_OK_CMD ||
                       host_cmd_code_i == dpx_pkg::ANS_ERR_CMD) begin
            h_kind = dpx_pkg::DPX_HR_ANSWER;
            err_d  = (host_cmd_code_i == dpx_pkg::ANS_ERR_CMD);
            irq_d  = 1'b0;
            st_d   = ST_TUN_RSP;
          end else begin
            busy_rst = 1'b1;
          end
        end else if (tmr_exp) begin
          irq_d = 1'b0;
          st_d  = ST_IDLE;
        end
      end
      ST_TUN_RSP: begin
        h_start = host_cmd;
        if (!hv_q && !rv_q && !rfgo_q && ri_q == 4'h0) begin
          rfgo_d = 1'b1;
        end
        if (rv_q && rl_q && rf_rsp_ready_i) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    excl_d = (st_d != ST_IDLE);
  end

  // ---------------------------------------------------------------------------
  // Host reply stream
  // ---------------------------------------------------------------------------
  always_comb begin
    hk_d   = hk_q;
    hi_d   = hi_q;
    hv_d   = hv_q;
    hl_d   = hl_q;
    hd_d   = hd_q;
    h_nidx = hi_q + 9'h001;
    if (h_start) begin
      hk_d   = h_kind;
      h_nidx = 9'h000;
    end
    h_byte = dpx_pkg::HOST_RSP_OK;
    h_last = 1'b1;
    case (hk_d)
      dpx_pkg::DPX_HR_BUSY: h_byte = dpx_pkg::HOST_RSP_BUSY;
      dpx_pkg::DPX_HR_FETCH: begin
        case (h_nidx)
          9'h000:  h_byte = dpx_pkg::HOST_RSP_OK;
          9'h001:  h_byte = tun_addr_i[15:8];
          9'h002:  h_byte = tun_addr_i[7:0];
          9'h003:  h_byte = tun_len_i;
          default: h_byte = tun_rd_data_i;
        endcase
        h_last = (h_nidx == dpx_pkg::FETCH_LEN_IDX + {1'b0, tun_len_i});
      end
      default: h_byte = dpx_pkg::HOST_RSP_OK;
    endcase
    if (h_start || (hv_q && host_rsp_ready_i && !hl_q)) begin
      hi_d = h_nidx;
      hv_d = 1'b1;
      hd_d = h_byte;
      hl_d = h_last;
    end else if (hv_q && host_rsp_ready_i) begin
      hv_d = 1'b0;
    end
    // Address runs one byte ahead so the buffer data is ready on handshake
    ra_d = 8'(hi_d + 9'h001 - dpx_pkg::FETCH_HDR_LEN);
  end

  // ---------------------------------------------------------------------------
  // Reader reply stream
  // ---------------------------------------------------------------------------
  always_comb begin
    ri_d   = ri_q;
    rv_d   = rv_q;
    rl_d   = rl_q;
    rd_d   = rd_q;
    r_nidx = rfgo_q ? 4'h0 : ri_q + 4'h1;
    if (rf_type_b_i) begin
      r_byte = (r_nidx == 4'h0) ? sw1_i : sw2_i;
      r_last = (r_nidx == dpx_pkg::TYPEB_LAST_IDX);
    end else begin
      if (r_nidx == 4'h0) begin
        r_byte = dpx_pkg::TUN_WR_RSP_CODE;
      end else if (r_nidx < dpx_pkg::JIS_ST1_IDX) begin
        r_byte = card_id_i[8'(8 * (9 - r_nidx) - 1) -: 8];
      end else if (err_q) begin
        r_byte = dpx_pkg::TUN_ST_ERR;
      end else begin
        r_byte = (r_nidx == dpx_pkg::JIS_ST1_IDX) ? stat1_i : stat2_i;
      end
      r_last = (r_nidx == dpx_pkg::JIS_LAST_IDX);
    end
    if (rfgo_q || (rv_q && rf_rsp_ready_i && !rl_q)) begin
      ri_d = r_nidx;
      rv_d = 1'b1;
      rd_d = r_byte;
      rl_d = r_last;
    end else if (rv_q && rf_rsp_ready_i) begin
      rv_d = 1'b0;
      ri_d = 4'h0;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      {rxdone_q, irq_q, err_q, excl_q, opst_q, rfgo_q} <= 6'h00;
      hk_q <= dpx_pkg::DPX_HR_BUSY;
      hi_q <= 9'h000;
      {hv_q, hl_q, rv_q, rl_q} <= 4'h0;
      hd_q <= 8'h00;
      ra_q <= 8'h00;
      ri_q <= 4'h0;
      rd_q <= 8'h00;
    end else begin
      st_q     <= st_d;
      rxdone_q <= rxdone_d;
      irq_q    <= irq_d;
      err_q    <= err_d;
      excl_q   <= excl_d;
      opst_q   <= opst_d;
      rfgo_q   <= rfgo_d;
      hk_q     <= hk_d;
      hi_q     <= hi_d;
      hv_q     <= hv_d;
      hl_q     <= hl_d;
      hd_q     <= hd_d;
      ra_q     <= ra_d;
      ri_q     <= ri_d;
      rv_q     <= rv_d;
      rl_q     <= rl_d;
      rd_q     <= rd_d;
    end
  end
  assign host_op_start_o  = opst_q;
  assign host_rsp_valid_o = hv_q;
  assign host_rsp_data_o  = hd_q;
  assign host_rsp_last_o  = hl_q;
  assign rf_rsp_valid_o   = rv_q;
  assign rf_rsp_data_o    = rd_q;
  assign rf_rsp_last_o    = rl_q;
  assign tun_rd_addr_o    = ra_q;
  assign irq_o            = irq_q;
  assign exclusive_o      = excl_q;
  assign tun_err_o        = err_q;
endmodule // dpx_arbiter

// ==== inc/dpx_pkg.sv ====
// Constants shared by the exclusive-control command arbiter.
// Assumes a 100 MHz system clock; all byte codes are 8 bits wide.
package dpx_pkg;
  // ---------------------------------------------------------------------------
  // Clock and answer-wait timing
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_NS          = 10;
  localparam int unsigned ANSWER_WAIT_NS  = 1000000;
  localparam int unsigned ANSWER_WAIT_CYC = ANSWER_WAIT_NS / CLK_NS;

  // ---------------------------------------------------------------------------
  // Command and response codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] FETCH_REQUEST_CMD = 8'h28;
  localparam logic [7:0] ANS_OK_CMD        = 8'hF8;
  localparam logic [7:0] ANS_ERR_CMD       = 8'hE8;
  localparam logic [7:0] TUN_WR_RSP_CODE   = 8'h09;
  localparam logic [7:0] HOST_RSP_OK       = 8'h00;
  localparam logic [7:0] HOST_RSP_BUSY     = 8'h01;
  localparam logic [7:0] TUN_ST_ERR        = 8'hFF;

  // ---------------------------------------------------------------------------
  // Frame lengths and byte positions
  // ---------------------------------------------------------------------------
  localparam logic [3:0] JIS_LAST_IDX   = 4'hA;
  localparam logic [3:0] JIS_ST1_IDX    = 4'h9;
  localparam logic [3:0] TYPEB_LAST_IDX = 4'h1;
  localparam logic [8:0] FETCH_HDR_LEN  = 9'h004;
  localparam logic [8:0] FETCH_LEN_IDX  = 9'h003;

  typedef enum logic [1:0] {
    DPX_HR_BUSY,
    DPX_HR_FETCH,
    DPX_HR_ANSWER
  } dpx_hkind_t;
endpackage

// ==== design/dpx_wait_timer.sv ====
// Answer-wait timer: a down-counter that reloads on restart.
// Assumes restart and run come from logic on the same clock.
`timescale 1ns/10ps
module dpx_wait_timer #(
  parameter int unsigned LOAD = 100000
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic run_i,
  input  wire logic restart_i,
  output logic      expired_o
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        exp_q;
  logic        exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!run_i || restart_i) begin
      cnt_d = 32'(LOAD);
    end else if (cnt_q == 32'h0000_0001) begin
      exp_d = 1'b1;
      cnt_d = 32'(LOAD);
    end else begin
      cnt_d = cnt_q - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_q <= 32'(LOAD);
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired_o = exp_q;
endmodule // dpx_wait_timer

// ==== verif/dpx_arbiter_chk.sv ====
// Concurrent checks on the arbiter's lock, reply streams and wait timer.
// Assumes binding into dpx_arbiter; sees only its ports.
`timescale 1ns/10ps
module dpx_arbiter_chk #(
  parameter int unsigned ANSWER_WAIT_CYC = 50
) (
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire logic       rf_type_b_i,
  input wire logic [7:0] sw1_i,
  input wire logic       host_cmd_valid_i,
  input wire logic       host_addr_match_i,
  input wire logic [7:0] host_cmd_code_i,
  input wire logic       rf_rsp_ready_i,
  input wire logic       host_op_start_o,
  input wire logic       host_rsp_valid_o,
  input wire logic [7:0] host_rsp_data_o,
  input wire logic       host_rsp_last_o,
  input wire logic       rf_rsp_valid_o,
  input wire logic [7:0] rf_rsp_data_o,
  input wire logic       rf_rsp_last_o,
  input wire logic       irq_o,
  input wire logic       exclusive_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // ---------------------------------------------------------------------------
  // Wait tracking: cycles since the last busy while the host is awaited
  // ---------------------------------------------------------------------------
  logic        take;
  logic        ans_q, ans_d, vl_q;
  logic [31:0] cnt_q, cnt_d;
  assign take = host_cmd_valid_i && host_addr_match_i && !host_rsp_valid_o;
  always_comb begin
    cnt_d = cnt_q + 32'h1;
    if (!irq_o || (host_rsp_valid_o && !vl_q &&
        host_rsp_data_o == dpx_pkg::HOST_RSP_BUSY)) cnt_d = 32'h0;
    ans_d = irq_o && (ans_q || (take &&
      (host_cmd_code_i == dpx_pkg::ANS_OK_CMD ||
       host_cmd_code_i == dpx_pkg::ANS_ERR_CMD)));
  end
  always_ff @(posedge clk_sys_i) begin
    cnt_q <= rst_i ? 32'h0 : cnt_d;
    ans_q <= !rst_i && ans_d;
    vl_q  <= !rst_i && host_rsp_valid_o;
  end
  sequence s_busy;
    host_rsp_valid_o && host_rsp_last_o &&
      host_rsp_data_o == dpx_pkg::HOST_RSP_BUSY;
  endsequence
  property p_lock;
    exclusive_o && $past(exclusive_o) |-> !host_op_start_o;
  endproperty
  property p_busy;
    take && exclusive_o && host_cmd_code_i != dpx_pkg::FETCH_REQUEST_CMD &&
      host_cmd_code_i != dpx_pkg::ANS_OK_CMD &&
      host_cmd_code_i != dpx_pkg::ANS_ERR_CMD |=> s_busy;
  endproperty
  property p_fcode;
    $rose(rf_rsp_valid_o) && !rf_type_b_i |->
      rf_rsp_data_o == dpx_pkg::TUN_WR_RSP_CODE;
  endproperty
  property p_bfirst;
    $rose(rf_rsp_valid_o) && rf_type_b_i |-> rf_rsp_data_o == sw1_i;
  endproperty
  property p_span;
    rf_rsp_valid_o |-> exclusive_o;
  endproperty
  property p_end;
    rf_rsp_valid_o && rf_rsp_last_o && rf_rsp_ready_i |-> ##[1:2] !exclusive_o;
  endproperty
  property p_awt;
    irq_o |-> cnt_q < ANSWER_WAIT_CYC + 4;
  endproperty
  property p_early;
    $fell(irq_o) |-> ans_q || cnt_q + 4 >= ANSWER_WAIT_CYC;
  endproperty
  property p_order;
    $rose(irq_o) |-> !host_rsp_valid_o;
  endproperty
  a_lock: assert property (p_lock) else $error("start while locked");
  a_busy: assert property (p_busy) else $error("no busy reply");
  a_fcode: assert property (p_fcode) else $error("bad reply code");
  a_bfirst: assert property (p_bfirst) else $error("bad first sw");
  a_span: assert property (p_span) else $error("reply unlocked");
  a_end: assert property (p_end) else $error("lock stuck");
  a_awt: assert property (p_awt) else $error("wait overrun");
  a_early: assert property (p_early) else $error("early idle");
  a_order: assert property (p_order) else $error("irq before busy");
endmodule // dpx_arbiter_chk

bind dpx_arbiter dpx_arbiter_chk #(.ANSWER_WAIT_CYC(ANSWER_WAIT_CYC))
  i_dpx_arbiter_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rf_type_b_i(rf_type_b_i),
  .sw1_i(sw1_i), .host_cmd_valid_i(host_cmd_valid_i),
  .host_addr_match_i(host_addr_match_i), .host_cmd_code_i(host_cmd_code_i),
  .rf_rsp_ready_i(rf_rsp_ready_i), .host_op_start_o(host_op_start_o),
  .host_rsp_valid_o(host_rsp_valid_o), .host_rsp_data_o(host_rsp_data_o),
  .host_rsp_last_o(host_rsp_last_o), .rf_rsp_valid_o(rf_rsp_valid_o),
  .rf_rsp_data_o(rf_rsp_data_o), .rf_rsp_last_o(rf_rsp_last_o),
  .irq_o(irq_o), .exclusive_o(exclusive_o));

// ==== verif/dpx_sink_model.sv ====
// Reply sink standing in for the host or the reader on a reply stream.
// Assumes the system clock; stalls follow an LFSR while slow_i is high.
`timescale 1ns/10ps
module dpx_sink_model (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  output logic      ready_o
);
  logic [7:0] lfsr_q, lfsr_d;
  always_comb begin
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
  end
  // Ready is low in reset so no byte is taken before the far side is up
  always_ff @(posedge clk_sys_i) begin
    lfsr_q  <= rst_i ? 8'h5B : lfsr_d;
    ready_o <= !rst_i && (!slow_i || lfsr_q[0]);
  end
endmodule // dpx_sink_model

// ==== verif/dpx_arbiter_test.sv ====
// Self-checking bench for the exclusive-control arbiter.
// Assumes dpx_pkg, the checker and dpx_sink_model are compiled first.
`timescale 1ns/10ps
module dpx_arbiter_test;
  localparam int unsigned WAIT_CYC = 50;
  localparam logic [8:0]  BZ  = {1'h1, dpx_pkg::HOST_RSP_BUSY};
  logic        clk_sys_i = 1'h0;
  logic        rst_i = 1'h1;
  logic        rs = 1'h0, rt = 1'h0, re = 1'h0, rd = 1'h0, tb_b = 1'h0;
  logic [63:0] cid = 64'h0;
  logic [7:0]  st1 = 8'h0, st2 = 8'h0, sw1 = 8'h0, sw2 = 8'h0, hc = 8'h0;
  logic [15:0] taddr = 16'h0;
  logic [7:0]  tlen = 8'h1, trd, h_d, r_d, rda;
  logic        hv = 1'h0, hm = 1'h0, hi = 1'h0, hd = 1'h0, slow = 1'h0;
  logic        h_rdy, r_rdy, ost, h_v, h_l, r_v, r_l, irq, exc, terr;
  logic [8:0]  hq[$], rq[$];
  int          mismatches = 0, samples_checked = 0, starts = 0;
  int          seed;
  always #5 clk_sys_i = ~clk_sys_i;
  // Buffer model: byte k of the tunnel data is k ^ 5A
  assign trd = rda ^ 8'h5A;
  dpx_arbiter #(.ANSWER_WAIT_CYC(WAIT_CYC)) i_dpx_arbiter (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rf_cmd_start_i(rs),
    .rf_cmd_tunnel_i(rt), .rf_cmd_end_i(re), .rf_op_done_i(rd),
    .rf_type_b_i(tb_b), .card_id_i(cid), .stat1_i(st1), .stat2_i(st2),
    .sw1_i(sw1), .sw2_i(sw2), .tun_addr_i(taddr), .tun_len_i(tlen),
    .tun_rd_data_i(trd), .host_cmd_valid_i(hv), .host_addr_match_i(hm),
    .host_cmd_impl_i(hi), .host_cmd_code_i(hc), .host_op_done_i(hd),
    .host_rsp_ready_i(h_rdy), .rf_rsp_ready_i(r_rdy), .host_op_start_o(ost),
    .host_rsp_valid_o(h_v), .host_rsp_data_o(h_d), .host_rsp_last_o(h_l),
    .rf_rsp_valid_o(r_v), .rf_rsp_data_o(r_d), .rf_rsp_last_o(r_l),
    .tun_rd_addr_o(rda), .irq_o(irq), .exclusive_o(exc), .tun_err_o(terr));
  dpx_sink_model i_dpx_sink_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .slow_i(slow), .ready_o(h_rdy));
  dpx_sink_model i_dpx_sink_model_rf (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .slow_i(slow), .ready_o(r_rdy));
  always @(posedge clk_sys_i) begin
    if (h_v && h_rdy) hq.push_back({h_l, h_d});
    if (r_v && r_rdy) rq.push_back({r_l, r_d});
    if (ost) starts++;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string w, logic [8:0] s, logic [8:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", w, e, s);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic rfp(int w);
    @(negedge clk_sys_i);
    {rs, re, rd} = 3'h4 >> w;
    @(negedge clk_sys_i);
    {rs, re, rd} = 3'h0;
  endtask
  task automatic host(logic [7:0] c, logic m, logic i);
    @(negedge clk_sys_i);
    {hv, hm, hi, hc} = {1'h1, m, i, c};
    @(negedge clk_sys_i);
    hv = 1'h0;
  endtask
  task automatic expect_q(bit r, logic [8:0] e);
    int i;
    for (i = 0; i < 300 && (r ? rq.size() : hq.size()) == 0; i++) cyc(1);
    if (i == 300) begin
      mismatches++;
      complete_run();
    end
    chk(r ? "rf byte" : "host byte", r ? rq.pop_front() : hq.pop_front(), e);
  endtask
  function automatic logic [7:0] rc();
    return 8'h40 | 8'($random(seed) & 15);
  endfunction
  function automatic logic [8:0] e_rf(int i, logic b, logic er);
    if (b) return {i == 1, i == 0 ? sw1 : sw2};
    if (i == 0) return {1'h0, dpx_pkg::TUN_WR_RSP_CODE};
    if (i < 9) return {1'h0, cid[8 * (8 - i) +: 8]};
    return {i == 10, er ? dpx_pkg::TUN_ST_ERR : (i == 9 ? st1 : st2)};
  endfunction
  function automatic logic [8:0] e_fe(int i, int n);
    logic [7:0] v;
    v = 8'(i - 4) ^ 8'h5A;
    if (i == 0) v = dpx_pkg::HOST_RSP_OK;
    if (i == 1) v = taddr[15:8];
    if (i == 2) v = taddr[7:0];
    if (i == 3) v = 8'(n);
    return {i == 3 + n, v};
  endfunction
  // Answer code 00 stops the walk in the await state
  task automatic tunnel(logic b, logic [7:0] a);
    int n;
    int i;
    n = 1 + ($unsigned($random(seed)) % 8);
    {tlen, taddr, tb_b, rt} = {8'(n), 16'($random(seed)), b, 1'h1};
    rfp(0);
    cyc(2);
    chk("lock", exc, 1'h1);
    host(dpx_pkg::FETCH_REQUEST_CMD, 1'h1, 1'h1);
    expect_q(0, BZ);
    rfp(1);
    for (i = 0; i < 300 && irq !== 1'h1; i++) cyc(1);
    chk("irq", irq, 1'h1);
    if (irq !== 1'h1) complete_run();
    host(rc(), 1'h1, 1'h1);
    expect_q(0, BZ);
    if (a == 8'h00) return;
    host(dpx_pkg::FETCH_REQUEST_CMD, 1'h1, 1'h1);
    for (i = 0; i < n + 4; i++) expect_q(0, e_fe(i, n));
    host(a, 1'h1, 1'h1);
    expect_q(0, {1'h1, dpx_pkg::HOST_RSP_OK});
    for (i = 0; i < (b ? 2 : 11); i++)
      expect_q(1, e_rf(i, b, a == dpx_pkg::ANS_ERR_CMD));
    cyc(4);
    chk("unlock", exc, 1'h0);
    chk("err flag", terr, a == dpx_pkg::ANS_ERR_CMD);
    chk("irq clear", irq, 1'h0);
  endtask
  initial begin
    seed = 32'h3FEE806F;
    cid = {$random(seed), $random(seed)};
    {st1, st2, sw1, sw2} = $random(seed);
    repeat (5) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'h0;
    host(rc(), 1'h0, 1'h1);
    cyc(5);
    chk("no match", 9'(hq.size()), 9'h0);
    host(rc(), 1'h1, 1'h0);
    expect_q(0, BZ);
    host(rc(), 1'h1, 1'h1);
    host(rc(), 1'h1, 1'h1);
    expect_q(0, BZ);
    chk("starts", 9'(starts), 9'h1);
    hd = 1'h1;
    cyc(1);
    hd = 1'h0;
    cyc(10);
    hq.delete();
    $display("serial test done");
    rfp(0);
    cyc(2);
    chk("rf lock", exc, 1'h1);
    host(rc(), 1'h1, 1'h1);
    expect_q(0, BZ);
    rt = 1'h1;
    rfp(0);
    rfp(1);
    cyc(4);
    chk("no irq", irq, 1'h0);
    rfp(2);
    cyc(4);
    chk("rf unlock", exc, 1'h0);
    chk("no rf reply", 9'(rq.size()), 9'h0);
    $display("rf test done");
    for (int k = 0; k < 4; k++) begin
      slow = k[0];
      tunnel(k[1], k[0] ? dpx_pkg::ANS_ERR_CMD : dpx_pkg::ANS_OK_CMD);
    end
    slow = 1'h0;
    $display("tunnel test done");
    tunnel(1'h0, 8'h00);
    repeat (6) begin
      cyc(WAIT_CYC * 2 / 3);
      host(rc(), 1'h1, 1'h1);
      expect_q(0, BZ);
    end
    chk("still waiting", irq, 1'h1);
    cyc(WAIT_CYC + 10);
    chk("abandoned", irq, 1'h0);
    chk("idle", exc, 1'h0);
    $display("timer test done");
    complete_run();
  end
endmodule // dpx_arbiter_test
